// File: cps_defs.svh
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// Register offsets on the register port.
`define CPS_OFS_STATUS0 8'h00
`define CPS_OFS_STATUS1 8'h01
`define CPS_OFS_FLAGS_A 8'h04
`define CPS_OFS_FLAGS_B 8'h05
`define CPS_OFS_FLAGS_C 8'h06
`define CPS_OFS_MASK_A 8'h08
`define CPS_OFS_MASK_B 8'h09
`define CPS_OFS_MASK_C 8'h0a
`define CPS_OFS_MONITOR 8'h20

// Bit positions.
`define CPS_BIT_SLEEP 1
`define CPS_BIT_CHARGING 3
`define CPS_BIT_POWER 4
`define CPS_BIT_TOPOFF 3
`define CPS_BIT_COMPLETE 4
`define CPS_BIT_LOWCUR 7
`define CPS_BIT_CHG_END 3
`define CPS_BIT_GOOD_BAT 4
`define CPS_BIT_PRI_IN 5
`define CPS_BIT_SEC_IN 6
`define CPS_BIT_LOW_BAT_CUR 7
`define CPS_BIT_TOPOFF_DONE 7
`define CPS_BIT_CV 0
`define CPS_BIT_TERM_CMP 7

// Timing in milliseconds and derived cycle counts at 100 MHz.
`define CPS_CLK_KHZ 100000
`define CPS_DEGLITCH_MS 30
`define CPS_TOPOFF_DELAY_MS 400
`define CPS_RETRY_MS 5000
`define CPS_DEGLITCH_CYC (`CPS_DEGLITCH_MS * `CPS_CLK_KHZ)
`define CPS_TOPOFF_DELAY_CYC (`CPS_TOPOFF_DELAY_MS * `CPS_CLK_KHZ)
`define CPS_RETRY_CYC (`CPS_RETRY_MS * `CPS_CLK_KHZ)

`endif

// File: cps_pkg.sv
package cps_pkg;

    typedef enum logic [4:0] {
        CPS_SLEEP = 5'h01,
        CPS_CHARGE = 5'h02,
        CPS_WAIT_TOPOFF = 5'h04,
        CPS_TOPOFF = 5'h08,
        CPS_DONE = 5'h10
    } cps_state_t;

    typedef enum logic [2:0] {
        CPS_SW_OFF = 3'h1,
        CPS_SW_SENSE = 3'h2,
        CPS_SW_FULL = 3'h4
    } cps_switch_t;

endpackage : cps_pkg

// File: cps_charge_phase_sequencer.sv
`timescale 1ns/1ps
`include "cps_defs.svh"
// Functional notes
// - Good-battery threshold crossing raises an interrupt; charge parameters stay untouched.
// - Good-battery event at flags A bit 4; power-good status at 00h bit 4.
// - Reaching float voltage switches current regulation to voltage regulation.
// - Voltage-regulation monitor bit is one exactly while in voltage regulation.
// - Enabled termination after 30 ms low current stops charge, opens switch, interrupts.
// - Without recharge disable, charging restarts below float minus hysteresis.
// - Termination only during voltage regulation with no other loop or supplemental.
// - Termination sets charge-end flag A bit 3 and complete status 01h bit 4.
// - Termination disabled: low current keeps charging, sets flag B bit 7 and monitors.
// - With top-off enabled, top-off starts 400 ms after charge end, status pin high.
// - During top-off, absence detection retried every 5 s unless disabled.
// - Top-off ends when its timer expires, setting flag C bit 7.
// - Top-off-active status at 01h bit 3 while top-off runs.
// - System-below-battery turns switch fully on; system-above returns it to sensing.
// - Sleep or high impedance: switch on; charge disable or path off: switch off.
// - Source loss stops charging, enters sleep, sets input flags and sleep status.
// - Status pin low while charging, high after termination and during top-off.
// - Charging status bit is one while charging, except during top-off.
// - Interrupt pin low while any unmasked flag is set, until all read and cleared.
// - Event arriving during a read of its register is buffered, then written after.
// - Mask bits stop the pin but the flag is still set.
module cps_charge_phase_sequencer #(
    parameter int unsigned DEGLITCH_CYC = `CPS_DEGLITCH_CYC,
    parameter int unsigned TOPOFF_DELAY_CYC = `CPS_TOPOFF_DELAY_CYC,
    parameter int unsigned RETRY_CYC = `CPS_RETRY_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port: read strobe stands for the whole read access.
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Control settings from the configuration registers.
    input wire logic termination_enable_i,
    input wire logic topoff_enable_i,
    input wire logic recharge_disable_i,
    input wire logic topoff_absence_detect_disable_i,
    input wire logic high_impedance_select_i,
    input wire logic charge_disable_i,
    input wire logic power_path_off_i,
    // Analog comparators and loop states.
    input wire logic good_battery_cmp_i,
    input wire logic float_reached_i,
    input wire logic below_term_current_i,
    input wire logic below_recharge_i,
    input wire logic input_voltage_loop_i,
    input wire logic input_current_loop_i,
    input wire logic charge_current_loop_i,
    input wire logic sys_below_bat_i,
    input wire logic sys_above_bat_i,
    input wire logic primary_input_present_i,
    input wire logic secondary_input_present_i,
    input wire logic source_valid_i,
    input wire logic topoff_timer_done_i,
    // Outputs to the analog side and pins.
    output logic voltage_regulation_o,
    output logic charging_o,
    output logic topoff_timer_run_o,
    output logic absence_detect_o,
    output logic [2:0] battery_switch_o,
    output logic stat_n_o,
    output logic int_n_o
);

    typedef struct packed {
        cps_pkg::cps_state_t state;
        logic cv;
        cps_pkg::cps_switch_t sw;
        logic supp;
        logic [31:0] cnt;
        logic [31:0] retry;
        logic [2:0][7:0] flags;
        logic [2:0][7:0] pend;
        logic [2:0][7:0] mask;
        logic [2:0][7:0] taken;
        logic [2:0] rd_act;
        logic good_q;
        logic pri_q;
        logic sec_q;
        logic low_q;
        logic complete;
        logic low_status;
        logic det;
        logic stat_n;
        logic [7:0] rdata;
    } cps_regs_t;

    cps_regs_t r;
    cps_regs_t next_r;

    logic [2:0][7:0] ev;
    logic term_ok;
    logic low_cur;

    always_comb begin
        next_r = r;
        ev = '0;
        low_cur = below_term_current_i & r.cv;
        // Termination only in voltage regulation with no other loop active.
        term_ok = low_cur & ~input_voltage_loop_i & ~input_current_loop_i
            & ~charge_current_loop_i & ~r.supp;
        next_r.good_q = good_battery_cmp_i;
        next_r.pri_q = primary_input_present_i;
        next_r.sec_q = secondary_input_present_i;
        next_r.low_q = low_cur;
        next_r.det = 1'b0;
        // Crossing the threshold only raises a flag.
        ev[0][`CPS_BIT_GOOD_BAT] = good_battery_cmp_i ^ r.good_q;
        ev[0][`CPS_BIT_PRI_IN] = primary_input_present_i ^ r.pri_q;
        ev[0][`CPS_BIT_SEC_IN] = secondary_input_present_i ^ r.sec_q;
        unique case (r.state)
            cps_pkg::CPS_SLEEP: begin
                next_r.cv = 1'b0;
                if (source_valid_i) begin
                    next_r.state = cps_pkg::CPS_CHARGE;
                    next_r.cnt = '0;
                end
            end
            cps_pkg::CPS_CHARGE: begin
                if (float_reached_i) begin
                    next_r.cv = 1'b1;
                end
                next_r.low_status = low_cur;
                if (termination_enable_i && term_ok) begin
                    if (r.cnt >= DEGLITCH_CYC) begin
                        next_r.cnt = '0;
                        next_r.cv = 1'b0;
                        ev[0][`CPS_BIT_CHG_END] = 1'b1;
                        next_r.complete = 1'b1;
                        next_r.stat_n = 1'b1;
                        next_r.state = topoff_enable_i ? cps_pkg::CPS_WAIT_TOPOFF
                            : cps_pkg::CPS_DONE;
                    end else begin
                        next_r.cnt = r.cnt + 32'h1;
                    end
                end else begin
                    next_r.cnt = '0;
                end
                if (!termination_enable_i && low_cur && !r.low_q) begin
                    ev[1][`CPS_BIT_LOW_BAT_CUR] = 1'b1;
                end
            end
            cps_pkg::CPS_WAIT_TOPOFF: begin
                if (r.cnt >= TOPOFF_DELAY_CYC - 1) begin
                    next_r.cnt = '0;
                    next_r.retry = '0;
                    next_r.state = cps_pkg::CPS_TOPOFF;
                end else begin
                    next_r.cnt = r.cnt + 32'h1;
                end
            end
            cps_pkg::CPS_TOPOFF: begin
                if (r.retry >= RETRY_CYC - 1) begin
                    next_r.retry = '0;
                    next_r.det = ~topoff_absence_detect_disable_i;
                end else begin
                    next_r.retry = r.retry + 32'h1;
                end
                if (topoff_timer_done_i) begin
                    ev[2][`CPS_BIT_TOPOFF_DONE] = 1'b1;
                    next_r.state = cps_pkg::CPS_DONE;
                end
            end
            cps_pkg::CPS_DONE: begin
                if (!recharge_disable_i && below_recharge_i) begin
                    next_r.state = cps_pkg::CPS_CHARGE;
                    next_r.complete = 1'b0;
                    next_r.stat_n = 1'b0;
                    next_r.cnt = '0;
                end
            end
            default: begin
                next_r.state = cps_pkg::CPS_SLEEP;
            end
        endcase
        if (r.state != cps_pkg::CPS_SLEEP && !source_valid_i) begin
            next_r.state = cps_pkg::CPS_SLEEP;
            next_r.cv = 1'b0;
            next_r.stat_n = 1'b1;
        end
        if (r.state == cps_pkg::CPS_SLEEP && source_valid_i) begin
            next_r.stat_n = 1'b0;
        end
        // Supplemental switching in every state, sleep included.
        if (sys_below_bat_i) begin
            next_r.supp = 1'b1;
        end else if (sys_above_bat_i) begin
            next_r.supp = 1'b0;
        end
        // Switch mode priority.
        if (power_path_off_i) begin
            next_r.sw = cps_pkg::CPS_SW_OFF;
            next_r.supp = 1'b0;
        end else if (next_r.state == cps_pkg::CPS_SLEEP || high_impedance_select_i) begin
            next_r.sw = cps_pkg::CPS_SW_FULL;
        end else if (next_r.supp) begin
            next_r.sw = cps_pkg::CPS_SW_FULL;
        end else if (charge_disable_i || next_r.state == cps_pkg::CPS_DONE
                || next_r.state == cps_pkg::CPS_WAIT_TOPOFF) begin
            next_r.sw = cps_pkg::CPS_SW_OFF;
        end else begin
            next_r.sw = cps_pkg::CPS_SW_SENSE;
        end
        // Flag registers: read snapshot, clear on read end, buffered events.
        for (int i = 0; i < 3; i++) begin
            next_r.rd_act[i] = reg_rd_i && reg_addr_i == (`CPS_OFS_FLAGS_A + 8'(i));
            if (r.rd_act[i] && !next_r.rd_act[i]) begin
                next_r.flags[i] = (r.flags[i] & ~r.taken[i]) | r.pend[i] | ev[i];
                next_r.pend[i] = '0;
            end else if (next_r.rd_act[i]) begin
                if (!r.rd_act[i]) begin
                    next_r.taken[i] = r.flags[i];
                end
                next_r.pend[i] = r.pend[i] | ev[i];
            end else begin
                next_r.flags[i] = r.flags[i] | ev[i];
            end
            if (reg_wr_i && reg_addr_i == (`CPS_OFS_MASK_A + 8'(i))) begin
                next_r.mask[i] = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `CPS_OFS_STATUS0: next_r.rdata = {3'h0,
                    good_battery_cmp_i,
                    r.state == cps_pkg::CPS_CHARGE,
                    1'b0, r.state == cps_pkg::CPS_SLEEP, 1'b0};
                `CPS_OFS_STATUS1: next_r.rdata = {r.low_status, 2'h0, r.complete,
                    r.state == cps_pkg::CPS_TOPOFF, 3'h0};
                `CPS_OFS_FLAGS_A: next_r.rdata = r.rd_act[0] ? r.taken[0] : r.flags[0];
                `CPS_OFS_FLAGS_B: next_r.rdata = r.rd_act[1] ? r.taken[1] : r.flags[1];
                `CPS_OFS_FLAGS_C: next_r.rdata = r.rd_act[2] ? r.taken[2] : r.flags[2];
                `CPS_OFS_MASK_A: next_r.rdata = r.mask[0];
                `CPS_OFS_MASK_B: next_r.rdata = r.mask[1];
                `CPS_OFS_MASK_C: next_r.rdata = r.mask[2];
                `CPS_OFS_MONITOR: next_r.rdata = {low_cur, 6'h0, r.cv};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= '{state: cps_pkg::CPS_SLEEP, sw: cps_pkg::CPS_SW_FULL,
                stat_n: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o = r.rdata;
    assign voltage_regulation_o = r.cv;
    assign charging_o = r.state == cps_pkg::CPS_CHARGE || r.state == cps_pkg::CPS_TOPOFF;
    assign topoff_timer_run_o = r.state == cps_pkg::CPS_TOPOFF;
    assign absence_detect_o = r.det;
    assign battery_switch_o = r.sw;
    assign stat_n_o = r.stat_n;
    // Unmasked set flags hold the pin low.
    assign int_n_o = ~|({r.flags[2], r.flags[1], r.flags[0]}
        & ~{r.mask[2], r.mask[1], r.mask[0]});

    cv_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        r.state != cps_pkg::CPS_CHARGE |=> !voltage_regulation_o)
        else $error("voltage regulation flag set outside charging");
    end_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0][`CPS_BIT_CHG_END] |=> r.complete && stat_n_o)
        else $error("termination did not set complete and status pin");
    term_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[0][`CPS_BIT_CHG_END] |-> termination_enable_i && r.cv)
        else $error("termination outside voltage regulation");
    topoff_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        r.state == cps_pkg::CPS_WAIT_TOPOFF && $past(r.state) == cps_pkg::CPS_CHARGE
        |-> stat_n_o)
        else $error("status pin low before top-off");
    topoff_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ev[2][`CPS_BIT_TOPOFF_DONE] && !next_r.rd_act[2] |=> r.flags[2][7])
        else $error("top-off complete flag not set");
    path_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        power_path_off_i |=> battery_switch_o == cps_pkg::CPS_SW_OFF)
        else $error("switch not off with power path off");
    sleep_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !source_valid_i |=> r.state == cps_pkg::CPS_SLEEP)
        else $error("source loss did not enter sleep");
    int_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        |({r.flags[2], r.flags[1], r.flags[0]} & ~{r.mask[2], r.mask[1], r.mask[0]})
        |-> !int_n_o)
        else $error("interrupt pin high with unmasked flag");
    read_buf_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        r.rd_act[0] && ev[0] != 8'h00 && !reg_rd_i |=> (r.flags[0] & $past(ev[0])) != 8'h00)
        else $error("event during read was lost");

endmodule : cps_charge_phase_sequencer

// File: cps_host_model.sv
`timescale 1ns/1ps
module cps_host_model (
    // Clock.
    input wire logic clk_i,
    // Register port towards the sequencer.
    output logic [7:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h5a;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'ha5;
    end

    // Idle address and data show the inverse of the last value, not a stale copy.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= w;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~w;
    endtask : wr
endmodule : cps_host_model

// File: tb_charge_phase_sequencer.sv
`timescale 1ns/1ps
module tb_charge_phase_sequencer;
    localparam int DG = 8;
    localparam int TD = 16;
    localparam int RT = 10;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_rd, reg_wr;
    logic te = 0, topoff_enable = 0, rchg_dis = 0, abs_dis = 0, hz = 0, chg_dis = 0, pp_off = 0;
    logic good = 0, flt = 0, low_i = 0, rchg = 0, vloop = 0, iloop = 0, cloop = 0;
    logic sys_lo = 0, sys_hi = 0, pri = 0, sec = 0, src = 0, to_done = 0;
    logic vreg, chg, to_run, absd, stat_n, int_n;
    logic [2:0] sw;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 23;
    int pulses;

    always #5 clk_i = ~clk_i;

    cps_host_model u_host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
        .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

    cps_charge_phase_sequencer #(.DEGLITCH_CYC(DG), .TOPOFF_DELAY_CYC(TD), .RETRY_CYC(RT)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_rd_i(reg_rd),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .termination_enable_i(te), .topoff_enable_i(topoff_enable), .recharge_disable_i(rchg_dis),
        .topoff_absence_detect_disable_i(abs_dis), .high_impedance_select_i(hz),
        .charge_disable_i(chg_dis), .power_path_off_i(pp_off), .good_battery_cmp_i(good),
        .float_reached_i(flt), .below_term_current_i(low_i), .below_recharge_i(rchg),
        .input_voltage_loop_i(vloop), .input_current_loop_i(iloop),
        .charge_current_loop_i(cloop), .sys_below_bat_i(sys_lo), .sys_above_bat_i(sys_hi),
        .primary_input_present_i(pri), .secondary_input_present_i(sec),
        .source_valid_i(src), .topoff_timer_done_i(to_done), .voltage_regulation_o(vreg),
        .charging_o(chg), .topoff_timer_run_o(to_run), .absence_detect_o(absd),
        .battery_switch_o(sw), .stat_n_o(stat_n), .int_n_o(int_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Reads a register and compares the masked bits.
    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        u_host.rd(a, d);
        chk(d & m, e & m);
    endtask : rchk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wait_cyc

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_cyc(1);
        chk({7'h0, int_n}, 8'h01);
        chk({5'h0, sw}, 8'h04);
        pri <= 1'b1;
        sec <= 1'b1;
        src <= 1'b1;
        wait_cyc(3);
        chk({7'h0, int_n}, 8'h00);
        rchk(8'h04, 8'h60, 8'h60);
        wait_cyc(1);
        chk({7'h0, int_n}, 8'h01);
        chk({7'h0, stat_n}, 8'h00);
        chk({5'h0, sw}, 8'h02);
        rchk(8'h00, 8'h08, 8'h08);
        fork
            u_host.rd(8'h04, d);
            begin
                @(posedge clk_i);
                good <= 1'b1;
            end
        join
        wait_cyc(1);
        chk({7'h0, int_n}, 8'h00);
        rchk(8'h04, 8'h10, 8'h10);
        rchk(8'h00, 8'h10, 8'h10);
        u_host.wr(8'h08, 8'h10);
        good <= 1'b0;
        wait_cyc(3);
        chk({7'h0, int_n}, 8'h01);
        rchk(8'h04, 8'h10, 8'h10);
        u_host.wr(8'h08, 8'h00);
        sys_lo <= 1'b1;
        wait_cyc(1);
        sys_lo <= 1'b0;
        wait_cyc(2);
        chk({5'h0, sw}, 8'h04);
        sys_hi <= 1'b1;
        wait_cyc(1);
        sys_hi <= 1'b0;
        wait_cyc(2);
        chk({5'h0, sw}, 8'h02);
        chg_dis <= 1'b1;
        wait_cyc(3);
        chk({5'h0, sw}, 8'h01);
        chg_dis <= 1'b0;
        flt <= 1'b1;
        wait_cyc(3);
        chk({7'h0, vreg}, 8'h01);
        rchk(8'h20, 8'h01, 8'h01);
        low_i <= 1'b1;
        wait_cyc(DG + 4);
        rchk(8'h05, 8'h80, 8'h80);
        rchk(8'h01, 8'h90, 8'h80);
        rchk(8'h20, 8'h80, 8'h80);
        chk({7'h0, stat_n}, 8'h00);
        iloop <= 1'b1;
        vloop <= 1'b1;
        cloop <= 1'b1;
        te <= 1'b1;
        topoff_enable <= 1'b1;
        wait_cyc(DG + 4);
        rchk(8'h04, 8'h08, 8'h00);
        iloop <= 1'b0;
        vloop <= 1'b0;
        cloop <= 1'b0;
        wait_cyc(DG + 4);
        chk({7'h0, stat_n}, 8'h01);
        rchk(8'h04, 8'h08, 8'h08);
        wait_cyc(TD);
        chk({7'h0, to_run}, 8'h01);
        chk({7'h0, stat_n}, 8'h01);
        rchk(8'h01, 8'h08, 8'h08);
        rchk(8'h00, 8'h08, 8'h00);
        pulses = 0;
        repeat (3 * RT) begin
            @(negedge clk_i);
            pulses += int'(absd === 1'b1);
        end
        chk(8'(pulses), 8'h03);
        abs_dis <= 1'b1;
        pulses = 0;
        repeat (3 * RT) begin
            @(negedge clk_i);
            pulses += int'(absd === 1'b1);
        end
        chk(8'(pulses), 8'h00);
        to_done <= 1'b1;
        wait_cyc(1);
        to_done <= 1'b0;
        wait_cyc(2);
        rchk(8'h06, 8'h80, 8'h80);
        chk({7'h0, to_run}, 8'h00);
        flt <= 1'b0;
        low_i <= 1'b0;
        rchg <= 1'b1;
        wait_cyc(3);
        chk({7'h0, chg}, 8'h01);
        hz <= 1'b1;
        wait_cyc(2);
        chk({5'h0, sw}, 8'h04);
        hz <= 1'b0;
        pp_off <= 1'b1;
        wait_cyc(2);
        chk({5'h0, sw}, 8'h01);
        pp_off <= 1'b0;
        wait_cyc(2);
        chk({5'h0, sw}, 8'h02);
        src <= 1'b0;
        wait_cyc(3);
        chk({7'h0, chg}, 8'h00);
        chk({5'h0, sw}, 8'h04);
        rchk(8'h00, 8'h02, 8'h02);
        repeat (4) begin
            rchk(8'h30 | 8'($random(seed) & 8'h0f), 8'hff, 8'h00);
        end
        wrap_up();
    end
endmodule : tb_charge_phase_sequencer
